/* inc/pawa_pkg.sv */
// Purpose: Shared constants and types for the pixel array window addressing
// Assumes: One 25 MHz clock; 640 column registers, each selecting two columns
// Notes: Sub-sample offset tables are indexed by {swap_inner, swap_outer}
package pawa_pkg;
  localparam int COL_REGS = 640;
  localparam int ROWS = 1024;
  localparam int COL_AW = 10;
  localparam int PIX_CW = 11;
  localparam int ROW_AW = 10;
  localparam int DATA_W = 10;
  localparam int GAIN_W = 4;
  localparam int DAC_W = 7;
  localparam int FIFO_DEPTH = 8;

  // Calibration time in row blanking, in ns, and the clock rate in MHz
  localparam int CLK_MHZ = 25;
  localparam int CAL_NS = 3500;
  localparam int CAL_CYC = (CAL_NS * CLK_MHZ + 999) / 1000;
  localparam int CAL_CW = 7;
  localparam logic [CAL_CW-1:0] CAL_LAST = CAL_CW'(CAL_CYC - 1);

  localparam logic [COL_AW-1:0] COL_LAST = COL_AW'(COL_REGS - 1);
  localparam logic [ROW_AW-1:0] ROW_LAST = ROW_AW'(ROWS - 1);
  localparam logic [COL_AW-1:0] COL_STEP_FULL = 10'h001;
  localparam logic [COL_AW-1:0] COL_STEP_SUB = 10'h002;
  localparam logic [ROW_AW-1:0] ROW_STEP_FULL = 10'h001;
  localparam logic [ROW_AW-1:0] ROW_STEP_SKIP = 10'h003;

  // Offset inside a group of four read for the first and second pixel
  localparam logic [7:0] OFS_LO_TBL = 8'h84;
  localparam logic [7:0] OFS_HI_TBL = 8'hed;

  typedef struct packed {
    logic sub;
    logic swap_inner;
    logic swap_outer;
  } pawa_sub_s;

  typedef struct packed {
    logic [GAIN_W-1:0] gain;
    logic [DAC_W-1:0] coarse;
    logic [DAC_W-1:0] fine;
  } pawa_amp_s;

  typedef struct packed {
    logic [ROW_AW-1:0] row;
    logic [PIX_CW-1:0] col;
    logic odd;
    logic [DATA_W-1:0] data;
  } pawa_pix_s;

  localparam int PIX_W = $bits(pawa_pix_s);

  typedef enum {
    ST_IDLE,
    ST_CALIB,
    ST_SYNC,
    ST_READ
  } pawa_state_e;
endpackage

/* core/pawa_fifo.sv */
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: Single clock, synchronous active-low reset
// Notes: Full and empty come from an occupancy count
`timescale 1ns/1ns
module pawa_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk, // System clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic [WIDTH-1:0] in_data, // Write data
  input wire logic in_valid, // Write request
  output logic in_ready, // Room for one more word
  output logic [WIDTH-1:0] out_data, // Head word
  output logic out_valid, // Head word present
  input wire logic out_ready // Reader takes the head word
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [CW-1:0] count_ff;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready = (count_ff != CW'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign out_data = mem_ff[rd_ptr_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= ptr_inc(wr_ptr_ff);
      end
      if (pop) begin
        rd_ptr_ff <= ptr_inc(rd_ptr_ff);
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule

/* core/pawa_core.sv */
// Purpose: Column/row window addressing, bus merge and amplifier codes
// Assumes: Controller pins are asynchronous; array bus data is on clk
// Notes: Column pointer is held as its register position, not one-hot
`timescale 1ns/1ns
module pawa_core (
  input wire logic clk, // System (pixel) clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic row_start_pin, // Row start from controller, async
  input wire logic row_clock_pin, // Row clock from controller, async
  input wire logic col_sync_pin, // Column sync from controller, async
  input wire pawa_pkg::pawa_sub_s col_mode, // Column sub-sample and swaps
  input wire pawa_pkg::pawa_sub_s row_mode, // Row sub-sample and swaps
  input wire logic [9:0] col_win_start, // First column register of window
  input wire logic [9:0] col_win_end, // Last column register of window
  input wire logic [9:0] row_win_start, // First row of window
  input wire logic [9:0] row_win_end, // Last row of window
  input wire logic [9:0] bus_a_data, // Even column of selected pair
  input wire logic [9:0] bus_b_data, // Odd column of selected pair
  input wire pawa_pkg::pawa_amp_s amp_in, // New gain and offset codes
  input wire logic amp_load, // Take amp_in, one-cycle pulse
  input wire logic pix_ready, // Downstream accepts a pixel
  output pawa_pkg::pawa_pix_s pix_out, // Pixel with its address
  output logic pix_valid, // pix_out holds a pixel
  output logic [9:0] col_ptr, // Column register position, one clock late
  output logic [9:0] row_addr, // Physical row being read
  output pawa_pkg::pawa_amp_s amp_out, // Applied gain and offset codes
  output logic [6:0] offset_now, // Offset code for the current pixel
  output logic calib_busy, // Amplifier calibration running
  output logic line_active, // Column readout in progress
  output logic frame_active // Inside the row window
);
  // Maps a linear index to the physical one for the active pattern
  function automatic logic [10:0] map_idx(input logic [10:0] lin,
                                          input pawa_pkg::pawa_sub_s m);
    logic [2:0] sel;
    logic [1:0] ofs;
    sel = {m.swap_inner, m.swap_outer, 1'b0};
    ofs = lin[0] ? pawa_pkg::OFS_HI_TBL[sel +: 2]
                 : pawa_pkg::OFS_LO_TBL[sel +: 2];
    if (m.sub) begin
      map_idx = {lin[10:2], ofs};
    end else begin
      map_idx = lin;
    end
  endfunction

  // Two-stage synchronisers for the controller pins
  logic [2:0] pin_meta_ff;
  logic [2:0] pin_sync_ff;
  logic rclk_prev_ff;
  logic row_start_s;
  logic row_clock_s;
  logic col_sync_s;
  logic row_edge;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
      rclk_prev_ff <= 1'b0;
    end else begin
      pin_meta_ff <= {row_start_pin, row_clock_pin, col_sync_pin};
      pin_sync_ff <= pin_meta_ff;
      rclk_prev_ff <= pin_sync_ff[1];
    end
  end

  assign row_start_s = pin_sync_ff[2];
  assign row_clock_s = pin_sync_ff[1];
  assign col_sync_s = pin_sync_ff[0];
  assign row_edge = row_clock_s && !rclk_prev_ff;

  pawa_pkg::pawa_state_e state_ff;
  pawa_pkg::pawa_state_e nxt_state;
  pawa_pkg::pawa_sub_s col_mode_ff;
  pawa_pkg::pawa_sub_s row_mode_ff;
  logic [9:0] col_start_ff;
  logic [9:0] col_end_ff;
  logic [9:0] row_end_ff;
  logic [9:0] row_log_ff;
  logic [9:0] nxt_row_log;
  logic [9:0] row_addr_ff;
  logic [10:0] row_map;
  logic frame_ff;
  logic nxt_frame;
  logic [pawa_pkg::CAL_CW-1:0] cal_cnt_ff;
  logic [9:0] col_ptr_ff;
  logic [9:0] col_step;
  logic [10:0] col_next;
  logic phase_ff;
  logic synced_ff;
  logic row_go;
  logic row_load;
  logic fifo_in_ready;
  logic fifo_in_valid;
  pawa_pkg::pawa_pix_s fifo_in;
  pawa_pkg::pawa_pix_s fifo_out;
  logic fifo_out_valid;
  logic fifo_out_ready;
  pawa_pkg::pawa_pix_s pix_ff;
  logic pix_valid_ff;
  pawa_pkg::pawa_amp_s amp_ff;
  logic [6:0] offset_now_ff;

  // Row start only counts together with a row clock edge
  assign row_load = row_edge && row_start_s;
  assign row_go = row_edge && (row_start_s || frame_ff);

  // Row stepping: plain +1, or visit a pair and skip the next pair
  always_comb begin
    nxt_row_log = row_log_ff;
    nxt_frame = frame_ff;
    if (row_load) begin
      // Sub-sampled windows start on a pair aligned to a group of four
      nxt_row_log = row_mode.sub ? {row_win_start[9:2], 2'b00}
                                 : row_win_start;
      nxt_frame = 1'b1;
    end else if (row_edge && frame_ff) begin
      if (row_mode_ff.sub && row_log_ff[0]) begin
        nxt_row_log = row_log_ff + pawa_pkg::ROW_STEP_SKIP;
      end else begin
        nxt_row_log = row_log_ff + pawa_pkg::ROW_STEP_FULL;
      end
      // Wrap past the last row or overshoot of the window ends the frame
      if (nxt_row_log > row_end_ff || nxt_row_log < row_log_ff) begin
        nxt_frame = 1'b0;
      end
    end
  end

  // The pattern of a new frame applies from its first row
  assign row_map = map_idx({1'b0, nxt_row_log},
                           row_load ? row_mode : row_mode_ff);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      row_log_ff <= '0;
      row_addr_ff <= '0;
      frame_ff <= 1'b0;
    end else begin
      row_log_ff <= nxt_row_log;
      frame_ff <= nxt_frame;
      row_addr_ff <= row_map[pawa_pkg::ROW_AW-1:0];
    end
  end

  // Modes and window ends are frozen per frame so a mid-frame write
  // cannot leave the pointers on an illegal position
  always_ff @(posedge clk) begin
    if (!nrst) begin
      col_mode_ff <= '0;
      row_mode_ff <= '0;
      col_start_ff <= '0;
      col_end_ff <= pawa_pkg::COL_LAST;
      row_end_ff <= pawa_pkg::ROW_LAST;
    end else if (row_load) begin
      col_mode_ff <= col_mode;
      row_mode_ff <= row_mode;
      row_end_ff <= row_win_end;
      col_end_ff <= col_win_end;
      // Sub-sample: odd start dropped to even; 639 becomes 638
      col_start_ff <= col_mode.sub ? {col_win_start[9:1], 1'b0}
                                   : col_win_start;
    end
  end

  // Line sequence: calibration, column sync, then readout
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      pawa_pkg::ST_IDLE: begin
        if (row_go && nxt_frame) begin
          nxt_state = pawa_pkg::ST_CALIB;
        end
      end
      pawa_pkg::ST_CALIB: begin
        if (cal_cnt_ff == pawa_pkg::CAL_LAST) begin
          nxt_state = pawa_pkg::ST_SYNC;
        end
      end
      pawa_pkg::ST_SYNC: begin
        if (synced_ff && !col_sync_s) begin
          nxt_state = pawa_pkg::ST_READ;
        end
      end
      pawa_pkg::ST_READ: begin
        if (fifo_in_ready && phase_ff &&
            (col_next > {1'b0, col_end_ff} ||
             col_next > {1'b0, pawa_pkg::COL_LAST})) begin
          nxt_state = pawa_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = pawa_pkg::ST_IDLE;
      end
    endcase
    // A new row clock restarts the line from blanking
    if (row_go) begin
      nxt_state = nxt_frame ? pawa_pkg::ST_CALIB : pawa_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_ff <= pawa_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cal_cnt_ff <= '0;
    end else if (state_ff == pawa_pkg::ST_CALIB &&
                 nxt_state == pawa_pkg::ST_CALIB) begin
      cal_cnt_ff <= cal_cnt_ff + 1'b1;
    end else begin
      cal_cnt_ff <= '0;
    end
  end

  // Column pointer: pair select, stepping every second clock
  assign col_step = col_mode_ff.sub ? pawa_pkg::COL_STEP_SUB
                                    : pawa_pkg::COL_STEP_FULL;
  assign col_next = {1'b0, col_ptr_ff} + {1'b0, col_step};

  always_ff @(posedge clk) begin
    if (!nrst) begin
      col_ptr_ff <= '0;
      phase_ff <= 1'b0;
      synced_ff <= 1'b0;
    end else if (state_ff == pawa_pkg::ST_SYNC) begin
      phase_ff <= 1'b0;
      if (col_sync_s) begin
        col_ptr_ff <= col_start_ff;
        synced_ff <= 1'b1;
      end
    end else if (state_ff == pawa_pkg::ST_READ) begin
      synced_ff <= 1'b0;
      // A full FIFO holds the pointer; nothing is skipped
      if (fifo_in_ready) begin
        phase_ff <= !phase_ff;
        if (phase_ff) begin
          col_ptr_ff <= col_next[9:0];
        end
      end
    end else begin
      synced_ff <= 1'b0;
      phase_ff <= 1'b0;
    end
  end

  // Bus A on the first clock of a pair, bus B on the second
  assign fifo_in_valid = (state_ff == pawa_pkg::ST_READ);
  always_comb begin
    fifo_in.row = row_addr_ff;
    fifo_in.col = map_idx({col_ptr_ff, phase_ff}, col_mode_ff);
    fifo_in.odd = phase_ff;
    fifo_in.data = phase_ff ? bus_b_data : bus_a_data;
  end

  pawa_fifo #(
    .WIDTH(pawa_pkg::PIX_W),
    .DEPTH(pawa_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_data(fifo_in),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready)
  );

  // Output register; refills in the same cycle it is taken, so full rate
  assign fifo_out_ready = !pix_valid_ff || pix_ready;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pix_ff <= '0;
      pix_valid_ff <= 1'b0;
    end else if (fifo_out_ready) begin
      pix_ff <= fifo_out;
      pix_valid_ff <= fifo_out_valid;
    end
  end

  // Gain and offset codes; the DAC references themselves are analog
  always_ff @(posedge clk) begin
    if (!nrst) begin
      amp_ff <= '0;
    end else if (amp_load) begin
      amp_ff <= amp_in;
    end
  end

  // Fine trim only offsets the odd-column group against the even one
  always_ff @(posedge clk) begin
    if (!nrst) begin
      offset_now_ff <= '0;
    end else if (fifo_out_ready && fifo_out_valid && fifo_out.odd) begin
      offset_now_ff <= amp_ff.fine;
    end else if (fifo_out_ready && fifo_out_valid) begin
      offset_now_ff <= amp_ff.coarse;
    end
  end

  logic calib_ff;
  logic line_ff;
  logic [9:0] col_ptr_out_ff;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      calib_ff <= 1'b0;
      line_ff <= 1'b0;
      col_ptr_out_ff <= '0;
    end else begin
      calib_ff <= (nxt_state == pawa_pkg::ST_CALIB);
      line_ff <= (nxt_state == pawa_pkg::ST_READ);
      col_ptr_out_ff <= col_ptr_ff;
    end
  end

  assign pix_out = pix_ff;
  assign pix_valid = pix_valid_ff;
  assign col_ptr = col_ptr_out_ff;
  assign row_addr = row_addr_ff;
  assign amp_out = amp_ff;
  assign offset_now = offset_now_ff;
  assign calib_busy = calib_ff;
  assign line_active = line_ff;
  assign frame_active = frame_ff;
endmodule

/* tb/pawa_core_properties.sv */
// Purpose: Port-level properties of the window addressing core
// Assumes: One clock; modes and windows change only between lines
// Notes: Calibration length is counted in helper logic
`timescale 1ns/1ns
module pawa_core_props (
  input wire logic clk, // System clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic row_start_pin, // Row start pin
  input wire logic row_clock_pin, // Row clock pin
  input wire logic col_sync_pin, // Column sync pin
  input wire pawa_pkg::pawa_sub_s col_mode, // Column mode
  input wire pawa_pkg::pawa_sub_s row_mode, // Row mode
  input wire pawa_pkg::pawa_amp_s amp_in, // Codes to load
  input wire logic amp_load, // Load strobe
  input wire logic pix_ready, // Downstream ready
  input wire pawa_pkg::pawa_pix_s pix_out, // Pixel
  input wire logic pix_valid, // Pixel valid
  input wire logic [9:0] col_ptr, // Column pointer
  input wire pawa_pkg::pawa_amp_s amp_out, // Applied codes
  input wire logic [6:0] offset_now, // Offset in use
  input wire logic calib_busy, // Calibration running
  input wire logic line_active // Column readout running
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  logic [7:0] cal_cnt_ff;
  always_ff @(posedge clk) begin
    if (!nrst || !calib_busy) begin
      cal_cnt_ff <= 8'h00;
    end else begin
      cal_cnt_ff <= cal_cnt_ff + 8'h01;
    end
  end

  sequence s_row_load;
    $rose(row_clock_pin) && row_start_pin;
  endsequence
  sequence s_calib_run;
    ##[1:8] $rose(calib_busy);
  endsequence
  sequence s_sync_done;
    !calib_busy && !col_sync_pin && $past(!col_sync_pin);
  endsequence
  // Load edge may itself move the pointer, so two settled cycles are needed
  sequence s_col_move;
    $changed(col_ptr) && line_active && $past(line_active) &&
      $past(line_active, 2);
  endsequence

  AST_CAL_START: assert property (s_row_load |-> s_calib_run)
    else $error("calibration did not start after row start");
  AST_CAL_LEN: assert property ($fell(calib_busy) |->
    cal_cnt_ff == 8'(pawa_pkg::CAL_CYC))
    else $error("calibration length wrong");
  AST_LINE_START: assert property ($rose(line_active) |-> s_sync_done)
    else $error("readout began before column sync release");
  AST_COL_STEP: assert property (s_col_move |->
    col_ptr == $past(col_ptr) + (col_mode.sub ? 10'h002 : 10'h001)
    ##1 $stable(col_ptr))
    else $error("column pointer step wrong");
  AST_AMP_LOAD: assert property (amp_load |=>
    amp_out == $past(amp_in))
    else $error("amplifier codes not applied");
  // Offset code is loaded together with the pixel now on the output
  AST_OFFSET: assert property (pix_valid && pix_ready |=>
    !pix_valid || offset_now == (pix_out.odd ? $past(amp_out.fine) :
    $past(amp_out.coarse)))
    else $error("offset code does not follow column parity");
  AST_PIX_HOLD: assert property (pix_valid && !pix_ready |=>
    pix_valid && $stable(pix_out))
    else $error("pixel dropped while stalled");
  // A single swap reads two columns of one parity; bit 1 then tells the bus
  AST_ODD_BUS: assert property (pix_valid |-> pix_out.odd ==
    ((col_mode.sub && (col_mode.swap_inner ^ col_mode.swap_outer)) ?
    pix_out.col[1] : pix_out.col[0]))
    else $error("bus flag disagrees with column parity");
  AST_COL_INNER: assert property (pix_valid && col_mode == 3'b110 |->
    !pix_out.col[0])
    else $error("inner swap pattern wrong");
  AST_COL_OUTER: assert property (pix_valid && col_mode == 3'b101 |->
    pix_out.col[0])
    else $error("outer swap pattern wrong");
  AST_ROW_SUB: assert property (pix_valid && row_mode == 3'b100 |->
    !pix_out.row[1])
    else $error("row sub-sample pattern wrong");
endmodule

bind pawa_core pawa_core_props pawa_core_props_i (.clk, .nrst,
  .row_start_pin, .row_clock_pin, .col_sync_pin, .col_mode, .row_mode,
  .amp_in, .amp_load, .pix_ready, .pix_out, .pix_valid, .col_ptr,
  .amp_out, .offset_now, .calib_busy, .line_active);

/* tb/pawa_cam_ctrl.sv */
// Purpose: Camera controller and pixel array bus model
// Assumes: Pins change just after rising clock edges
// Notes: Fixed bus codes reveal which bus a pixel came from
`timescale 1ns/1ns
module pawa_cam_ctrl #(
  parameter logic [9:0] A_CODE = 10'h155,
  parameter logic [9:0] B_CODE = 10'h2aa
) (
  input wire logic clk, // System clock
  input wire logic calib_busy, // Calibration running
  output logic row_start_pin, // Row start
  output logic row_clock_pin, // Row clock
  output logic col_sync_pin, // Column sync
  output logic [9:0] bus_a_data, // Even column
  output logic [9:0] bus_b_data // Odd column
);
  initial begin
    row_start_pin = 1'b0;
    row_clock_pin = 1'b0;
    col_sync_pin = 1'b0;
  end
  assign bus_a_data = A_CODE;
  assign bus_b_data = B_CODE;

  // Pins stay four clocks so the two-stage synchroniser cannot miss them
  task automatic row(input logic first);
    int n;
    row_start_pin <= first;
    row_clock_pin <= 1'b1;
    repeat (4) @(posedge clk);
    row_clock_pin <= 1'b0;
    row_start_pin <= 1'b0;
    n = 0;
    while (calib_busy !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    while (calib_busy !== 1'b0 && n < 200) begin
      @(posedge clk);
      n++;
    end
    col_sync_pin <= 1'b1;
    repeat (4) @(posedge clk);
    col_sync_pin <= 1'b0;
  endtask
endmodule

/* tb/pawa_core_tb_top.sv */
// Purpose: Self-checking bench for the window addressing core
// Assumes: Bench drives inputs by non-blocking assignment on rising edges
// Notes: Expected pixel lists follow the documented read patterns
`timescale 1ns/1ns
module pawa_core_tb_top;
  localparam logic [9:0] CODE_A = 10'h155;
  localparam logic [9:0] CODE_B = 10'h2aa;
  // Read offsets in a group of four for none, outer, inner, both swaps
  localparam int LO [4] = '{0, 1, 0, 2};
  localparam int HI [4] = '{1, 3, 2, 3};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic row_start_pin, row_clock_pin, col_sync_pin;
  pawa_pkg::pawa_sub_s col_mode = '0;
  pawa_pkg::pawa_sub_s row_mode = '0;
  logic [9:0] col_win_start = '0, col_win_end = '0;
  logic [9:0] row_win_start = '0, row_win_end = '0;
  logic [9:0] bus_a_data, bus_b_data, col_ptr, row_addr;
  pawa_pkg::pawa_amp_s amp_in = '0;
  pawa_pkg::pawa_amp_s amp_out;
  logic amp_load = 1'b0;
  logic pix_ready = 1'b1;
  pawa_pkg::pawa_pix_s pix_out;
  logic pix_valid, calib_busy, line_active, frame_active;
  logic [6:0] offset_now;
  int n_errors = 0;
  int samples_checked = 0;
  pawa_pkg::pawa_pix_s got[$];

  always #20 clk = ~clk;

  pawa_core pawa_core_i (.clk, .nrst, .row_start_pin, .row_clock_pin,
    .col_sync_pin, .col_mode, .row_mode, .col_win_start, .col_win_end,
    .row_win_start, .row_win_end, .bus_a_data, .bus_b_data, .amp_in,
    .amp_load, .pix_ready, .pix_out, .pix_valid, .col_ptr, .row_addr,
    .amp_out, .offset_now, .calib_busy, .line_active, .frame_active);

  pawa_cam_ctrl #(.A_CODE(CODE_A), .B_CODE(CODE_B)) pawa_cam_ctrl_i (
    .clk, .calib_busy, .row_start_pin, .row_clock_pin, .col_sync_pin,
    .bus_a_data, .bus_b_data);

  always @(posedge clk) begin
    if (pix_valid === 1'b1 && pix_ready === 1'b1) got.push_back(pix_out);
  end

  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One row clock, then wait until the line and the FIFO have drained
  task automatic line(input logic first);
    int n;
    got.delete();
    pawa_cam_ctrl_i.row(first);
    repeat (8) @(posedge clk);
    n = 0;
    while ((line_active !== 1'b0 || pix_valid !== 1'b0) && n < 800) begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic cmp_line(input int row, input int r0, input int r1,
    input bit sub, input int lo, input int hi);
    pawa_pkg::pawa_pix_s e;
    int c;
    check("pixel count", got.size(),
      (sub ? (r1 - r0) / 2 + 1 : r1 - r0 + 1) * 2);
    for (int r = r0; r <= r1; r += sub ? 2 : 1) begin
      for (int k = 0; k < 2; k++) begin
        c = 2 * r + (sub ? (k ? hi : lo) : k);
        e.row = 10'(row);
        e.col = 11'(c);
        // Bus A leads each pair even when a swap moves the columns
        e.odd = k[0];
        e.data = e.odd ? CODE_B : CODE_A;
        if (got.size() > 0) check("pixel", got.pop_front(), e);
      end
    end
  endtask

  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    check("valid after reset", pix_valid, 32'h0000_0000);
    @(posedge clk);
    amp_in <= {4'hf, 7'h55, 7'h2a};
    amp_load <= 1'b1;
    @(posedge clk);
    amp_load <= 1'b0;
    @(negedge clk);
    check("amp codes", amp_out, {4'hf, 7'h55, 7'h2a});
    @(posedge clk);
    // Swaps set without sub-sampling must have no effect
    col_mode <= 3'b011;
    row_mode <= 3'b011;
    col_win_start <= 10'h005;
    col_win_end <= 10'h007;
    row_win_start <= 10'h00a;
    row_win_end <= 10'h00b;
    line(1'b1);
    cmp_line(10, 5, 7, 1'b0, 0, 1);
    check("frame active", frame_active, 32'h0000_0001);
    check("row address", row_addr, 32'h0000_000a);
    line(1'b0);
    cmp_line(11, 5, 7, 1'b0, 0, 1);
    line(1'b0);
    check("lines past window end", got.size(), 32'h0000_0000);
    check("frame after window", frame_active, 32'h0000_0000);
    for (int m = 0; m < 4; m++) begin
      col_mode <= {1'b1, 2'(m)};
      row_mode <= {1'b1, 2'(m)};
      col_win_start <= 10'h003;
      col_win_end <= 10'h005;
      row_win_start <= 10'h009;
      row_win_end <= 10'h00d;
      line(1'b1);
      cmp_line(8 + LO[m], 2, 5, 1'b1, LO[m], HI[m]);
      line(1'b0);
      cmp_line(8 + HI[m], 2, 5, 1'b1, LO[m], HI[m]);
      check("row address", row_addr, 8 + HI[m]);
    end
    // Downstream stall long enough to fill the FIFO mid-line
    col_mode <= '0;
    row_mode <= '0;
    col_win_start <= 10'h000;
    col_win_end <= 10'h007;
    row_win_start <= 10'h000;
    row_win_end <= 10'h000;
    pix_ready <= 1'b0;
    fork
      begin
        repeat (200) @(posedge clk);
        pix_ready <= 1'b1;
      end
    join_none
    line(1'b1);
    cmp_line(0, 0, 7, 1'b0, 0, 1);
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
endmodule
